// File: rtl/ubr_pkg.sv
// Package for the break/idle transmitter and oversampled receiver block.
// Assumes a single 40 MHz module clock and an external oversample tick.
`default_nettype none
package ubr_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL  = 3'h0;
    localparam logic [2:0] ADDR_CFG   = 3'h1;
    localparam logic [2:0] ADDR_STAT  = 3'h2;
    localparam logic [2:0] ADDR_DATA  = 3'h3;
    localparam logic [2:0] ADDR_MATCH = 3'h4;
    // Status bit positions
    localparam int ST_TXE = 0;
    localparam int ST_RXF = 1;
    localparam int ST_OVR = 2;
    localparam int ST_NSE = 3;
    localparam int ST_FRM = 4;
    localparam int ST_IDL = 5;
    localparam int ST_BSY = 6;
    // Frame figures in bit times, reset oversample ratio minus one, and the three-ones edge history
    localparam logic [4:0] BRK_BASE  = 5'h0a;
    localparam logic [4:0] BRK_LONG  = 5'h03;
    localparam logic [3:0] DATA_BASE = 4'h8;
    localparam logic [4:0] CFG_OSR_RST = 5'h0f;
    localparam logic [2:0] HIST_ONES = 3'h7;

    typedef struct packed {
        logic match_second_enable;
        logic match_first_enable;
        logic idle_during_sleep_bit;
        logic wake_method_sel;
        logic rx_sleep_bit;
        logic send_break_bit;
        logic transmitter_enable_bit;
        logic receiver_enable_bit;
    } ubr_ctrl_t;

    typedef struct packed {
        logic [4:0] osr_m1;
        logic       idle_count_after_stop_sel;
        logic       msb_first_sel;
        logic       resync_disable;
        logic       both_edge_sel;
        logic       rx_invert_bit;
        logic       long_break_sel;
        logic       two_stop_sel;
        logic       ten_bit_sel;
        logic       nine_bit_sel;
    } ubr_cfg_t;

    typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} ubr_rx_st_t;
endpackage
`default_nettype wire

// File: rtl/ubr_core.sv
// Break and queued-idle transmitter plus oversampled receiver with wakeup.
// Assumes i_sample_tick pulses once per sample segment, synchronous inputs.
//
// What this block does
// - Break is all zeros, 10 bit times plus length options.
// - Send-break high then low queues one break; held high requeues.
// - Toggling transmitter enable off then on queues one idle character.
// - Serial output stays driven while a character is in the shifter.
// - Receive inversion option; receiver enable gates reception.
// - Frames: zero start, 8 to 10 data bits, 1 or 2 stop bits.
// - Store into empty buffer and set full; else set overrun, drop.
// - Falling edge is a zero sample after three one samples.
// - Start verified by two of three mid samples; new edge restarts.
// - Each bit is the majority of three middle samples.
// - Any disagreeing sample sets noise at transfer.
// - Both-edge mode doubles segments, samples at ratio, +1, +2.
// - Every falling edge after the start bit realigns sampling unless resync disabled.
// - Non-break framing error preloads edge history with three ones.
// - Sleep blocks receiver flags except idle with idle-during-sleep.
// - Idle-line wake clears sleep after one character of idle.
// - Idle-during-sleep set: idles flag in sleep as when awake; clear: waking idle silent.
// - Idle counting from start bit, or after stop when selected.
// - Address-mark wake: set last data bit clears sleep, char stored.
// - Marked address stored only when it matches an enabled value.
// - Data after matched address stored, after unmatched discarded.
// - Either enabled match accepts; no enables stores everything.
// - Error flags set with buffer full, never on overrun.
`default_nettype none
module ubr_core (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_sample_tick,
    input  wire logic        i_rx,
    output logic             o_tx,
    output logic             o_tx_oe,
    input  wire logic [2:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [15:0]      o_rdata
);
    ubr_pkg::ubr_ctrl_t ctrl;
    ubr_pkg::ubr_cfg_t  cfg;
    logic [7:0]  ma1;
    logic [7:0]  ma2;
    logic        rx_full, ovr, nse, frm, idl, armed, matched;
    logic [9:0]  rx_data;
    logic        tx_empty, brk_q, idle_q, busy, tx_brk;
    logic [9:0]  tx_buf;
    logic [15:0] tsh;
    logic [4:0]  tbits;
    logic [6:0]  tcnt;
    ubr_pkg::ubr_rx_st_t st;
    logic [2:0]  hist, samp;
    logic [6:0]  seg;
    logic [3:0]  bidx;
    logic [9:0]  rsh;
    logic        nacc, facc;
    logic [9:0]  icnt;

    wire wr_ctrl = i_wr && i_addr == ubr_pkg::ADDR_CTRL;
    wire wr_stat = i_wr && i_addr == ubr_pkg::ADDR_STAT;
    wire wr_data = i_wr && i_addr == ubr_pkg::ADDR_DATA;
    wire rd_data = i_rd && i_addr == ubr_pkg::ADDR_DATA;

    // Frame geometry
    logic [3:0] nb;
    logic [3:0] ns;
    logic [6:0] oversample_ratio, segs, mid;
    logic [4:0] chlen;
    logic [4:0] brklen;
    always_comb
    begin
        nb = cfg.ten_bit_sel ? 4'ha : (cfg.nine_bit_sel ? 4'h9 : ubr_pkg::DATA_BASE);
        ns = cfg.two_stop_sel ? 4'h2 : 4'h1;
        oversample_ratio = {2'h0, cfg.osr_m1} + 7'h01;
        segs = cfg.both_edge_sel ? {oversample_ratio[5:0], 1'b0} : oversample_ratio;
        mid = cfg.both_edge_sel ? oversample_ratio : {1'b0, oversample_ratio[6:1]};
        chlen = 5'h01 + {1'b0, nb} + {1'b0, ns};
        brklen = ubr_pkg::BRK_BASE
            + {4'h0, cfg.nine_bit_sel & ~cfg.ten_bit_sel}
            + {4'h0, cfg.two_stop_sel}
            + {3'h0, cfg.ten_bit_sel, 1'b0}
            + (cfg.long_break_sel ? ubr_pkg::BRK_LONG : 5'h00);
    end

    // Receive sampling
    wire rxs  = i_rx ^ cfg.rx_invert_bit;
    wire fall = i_sample_tick && !rxs && hist == ubr_pkg::HIST_ONES;
    wire at_s = i_sample_tick && seg >= mid && seg <= mid + 7'h02;
    wire last = i_sample_tick && seg == mid + 7'h02;
    wire [2:0] v3 = {samp[1:0], rxs};
    wire maj = (v3[0] & v3[1]) | (v3[0] & v3[2]) | (v3[1] & v3[2]);
    wire nz  = !(&v3) && |v3;
    wire [3:0] stopb = nb + ns;
    wire done = st == ubr_pkg::RX_BITS && last && bidx == stopb;
    wire fe_now = facc | ~maj;
    // Only the bits of this frame count: a longer earlier frame leaves bits behind
    wire brk_rx = fe_now && (rsh & (10'h3ff >> (4'ha - nb))) == 10'h000;
    wire wake_adr = st == ubr_pkg::RX_BITS && last && bidx == nb && maj
        && ctrl.rx_sleep_bit && ctrl.wake_method_sel;

    function automatic logic [9:0] rev(input logic [9:0] v, input logic [3:0] n);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 0; i < 10; i++)
            if (i < int'(n))
                r[i] = v[int'(n) - 1 - i];
        return r;
    endfunction

    wire [9:0] mask = 10'h3ff >> (4'ha - nb);
    wire [9:0] rval = cfg.msb_first_sel ? (rsh & mask) : rev(rsh, nb);
    wire men  = ctrl.match_first_enable | ctrl.match_second_enable;
    wire hit  = (ctrl.match_first_enable && rval[7:0] == ma1)
        || (ctrl.match_second_enable && rval[7:0] == ma2);
    wire keep = !men || (rsh[0] ? hit : matched);
    wire deliver = done && keep && !ctrl.rx_sleep_bit;
    wire full_eff = rx_full && !rd_data;
    wire store = deliver && !full_eff;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            hist <= 3'h0;
        else if (done && fe_now && !brk_rx)
            hist <= ubr_pkg::HIST_ONES;
        else if (i_sample_tick)
            hist <= {hist[1:0], rxs};
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            samp <= 3'h0;
        else if (at_s)
            samp <= v3;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= ubr_pkg::RX_HUNT;
            seg <= 7'h01;
            bidx <= 4'h0;
            rsh <= 10'h000;
            nacc <= 1'b0;
            facc <= 1'b0;
        end
        else if (!ctrl.receiver_enable_bit)
            st <= ubr_pkg::RX_HUNT;
        else
        begin
            // The falling sample is segment one, so the next tick is segment two
            case (st)
                ubr_pkg::RX_HUNT:
                    if (fall)
                    begin
                        st <= ubr_pkg::RX_START;
                        seg <= 7'h02;
                    end
                ubr_pkg::RX_START:
                    if (fall)
                        seg <= 7'h02;
                    else if (last)
                    begin
                        if (!maj)
                        begin
                            st <= ubr_pkg::RX_BITS;
                            nacc <= nz;
                            facc <= 1'b0;
                            bidx <= 4'h0;
                        end
                        else
                            st <= ubr_pkg::RX_HUNT;
                        seg <= seg + 7'h01;
                    end
                    else if (i_sample_tick)
                        seg <= seg + 7'h01;
                ubr_pkg::RX_BITS:
                begin
                    if (fall && !cfg.resync_disable)
                        seg <= 7'h02;
                    else if (i_sample_tick)
                    begin
                        if (seg == segs)
                        begin
                            seg <= 7'h01;
                            bidx <= bidx + 4'h1;
                        end
                        else
                            seg <= seg + 7'h01;
                    end
                    if (last && bidx != 4'h0)
                    begin
                        nacc <= nacc | nz;
                        if (bidx <= nb)
                            rsh <= {rsh[8:0], maj};
                        else
                            facc <= facc | ~maj;
                    end
                    if (done)
                        st <= ubr_pkg::RX_HUNT;
                end
                default:
                    st <= ubr_pkg::RX_HUNT;
            endcase
        end
    end

    // Idle-line detection
    wire [9:0] thr = {5'h00, chlen} * {3'h0, segs};
    wire ihold = cfg.idle_count_after_stop_sel && st != ubr_pkg::RX_HUNT;
    wire idle_hit = i_sample_tick && rxs && !ihold && icnt == thr - 10'h001
        && ctrl.receiver_enable_bit;
    wire wake_idl = idle_hit && ctrl.rx_sleep_bit && !ctrl.wake_method_sel;
    wire idl_set = idle_hit && armed
        && (!ctrl.rx_sleep_bit || ctrl.idle_during_sleep_bit);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            icnt <= 10'h000;
        else if (i_sample_tick)
        begin
            if (!rxs || ihold)
                icnt <= 10'h000;
            else if (icnt != thr)
                icnt <= icnt + 10'h001;
        end
    end

    // Receive buffer and flags; hardware sets win over software clears
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_full <= 1'b0;
            ovr <= 1'b0;
            nse <= 1'b0;
            frm <= 1'b0;
            idl <= 1'b0;
            armed <= 1'b0;
            rx_data <= 10'h000;
        end
        else
        begin
            rx_full <= store | full_eff;
            if (store)
                rx_data <= rval;
            ovr <= (deliver && full_eff)
                | (ovr & ~(wr_stat & i_wdata[ubr_pkg::ST_OVR]));
            nse <= (store && (nacc | nz))
                | (nse & ~(wr_stat & i_wdata[ubr_pkg::ST_NSE]));
            frm <= (store && fe_now)
                | (frm & ~(wr_stat & i_wdata[ubr_pkg::ST_FRM]));
            idl <= idl_set | (idl & ~(wr_stat & i_wdata[ubr_pkg::ST_IDL]));
            if (store)
                armed <= 1'b1;
            else if (idl_set)
                armed <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            matched <= 1'b0;
        else if (done && men && rsh[0] && !ctrl.rx_sleep_bit)
            matched <= hit;
    end

    // Control registers; a software write to sleep wins over a wake
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl <= '0;
            cfg <= '0;
            cfg.osr_m1 <= ubr_pkg::CFG_OSR_RST;
            ma1 <= 8'h00;
            ma2 <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= ubr_pkg::ubr_ctrl_t'(i_wdata[7:0]);
            else if (wake_idl || wake_adr)
                ctrl.rx_sleep_bit <= 1'b0;
            if (i_wr && i_addr == ubr_pkg::ADDR_CFG)
                cfg <= ubr_pkg::ubr_cfg_t'(i_wdata[13:0]);
            if (i_wr && i_addr == ubr_pkg::ADDR_MATCH)
            begin
                ma1 <= i_wdata[7:0];
                ma2 <= i_wdata[15:8];
            end
        end
    end

    // Transmitter: queues and one shifter for data, break and idle
    wire sbk_rise = wr_ctrl && i_wdata[2] && !ctrl.send_break_bit;
    wire te_rise = wr_ctrl && i_wdata[1] && !ctrl.transmitter_enable_bit;
    wire ld = !busy && ctrl.transmitter_enable_bit && (brk_q || idle_q || !tx_empty);
    wire ld_brk = ld && brk_q;
    wire ld_idl = ld && !brk_q && idle_q;
    wire ld_dat = ld && !brk_q && !idle_q;
    wire [9:0] tpay = cfg.msb_first_sel ? rev(tx_buf, nb) : tx_buf;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            brk_q <= 1'b0;
            idle_q <= 1'b0;
        end
        else
        begin
            brk_q <= sbk_rise || (ld_brk ? ctrl.send_break_bit : brk_q);
            idle_q <= te_rise || (idle_q && !ld_idl);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_empty <= 1'b1;
            tx_buf <= 10'h000;
        end
        else
        begin
            if (wr_data)
                tx_buf <= i_wdata[9:0];
            tx_empty <= ld_dat || (tx_empty && !wr_data);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy <= 1'b0;
            tx_brk <= 1'b0;
            tsh <= 16'hffff;
            tbits <= 5'h00;
            tcnt <= 7'h00;
        end
        else if (ld)
        begin
            busy <= 1'b1;
            tx_brk <= ld_brk;
            tcnt <= 7'h00;
            tbits <= ld_brk ? brklen : chlen;
            if (ld_brk)
                tsh <= 16'h0000;
            else if (ld_idl)
                tsh <= 16'hffff;
            else
                tsh <= ~(16'hffff << (nb + 4'h1)) & {5'h00, tpay, 1'b0}
                    | (16'hffff << (nb + 4'h1));
        end
        else if (busy && i_sample_tick)
        begin
            if (tcnt == segs - 7'h01)
            begin
                tcnt <= 7'h00;
                tsh <= {!tx_brk, tsh[15:1]};
                tbits <= tbits - 5'h01;
                if (tbits == 5'h01)
                    busy <= 1'b0;
            end
            else
                tcnt <= tcnt + 7'h01;
        end
    end

    assign o_tx = busy ? tsh[0] : 1'b1;
    assign o_tx_oe = ctrl.transmitter_enable_bit | busy;

    // Register read port, data one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 16'h0000;
        else if (i_rd)
        begin
            case (i_addr)
                ubr_pkg::ADDR_CTRL: o_rdata <= {8'h00, ctrl};
                ubr_pkg::ADDR_CFG: o_rdata <= {2'h0, cfg};
                ubr_pkg::ADDR_STAT: o_rdata <= {9'h000, busy, idl, frm, nse, ovr,
                    rx_full, tx_empty};
                ubr_pkg::ADDR_DATA: o_rdata <= {6'h00, rx_data};
                ubr_pkg::ADDR_MATCH: o_rdata <= {ma2, ma1};
                default: o_rdata <= 16'h0000;
            endcase
        end
        else
            o_rdata <= 16'h0000;
    end

    sequence s_brk_load;
        ld_brk && ctrl.send_break_bit;
    endsequence
    sequence s_overrun;
        deliver && full_eff;
    endsequence

    chk_break_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        busy && tx_brk |-> !o_tx) else $error("break bit not low");
    chk_break_requeue: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_brk_load |=> brk_q && busy) else $error("held break not requeued");
    chk_idle_queue: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        te_rise |=> idle_q || (busy && !tx_brk)) else $error("idle not queued");
    chk_tx_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        busy |-> o_tx_oe) else $error("output released mid character");
    chk_overrun_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_overrun |=> ovr && $stable(rx_data) && !$rose(nse)) else $error("overrun wrong");
    chk_edge_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        st == ubr_pkg::RX_HUNT && fall && ctrl.receiver_enable_bit
        |=> st == ubr_pkg::RX_START && seg == 7'h02)
        else $error("edge did not start hunt");
    chk_noise_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        store && nz |=> nse && rx_full) else $error("noise not flagged");
    chk_sleep_block: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctrl.rx_sleep_bit && !wake_adr |=> !$rose(rx_full) && !$rose(ovr))
        else $error("flag set while asleep");
    chk_match_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        done && men && !rsh[0] && !matched && !full_eff |=> !rx_full)
        else $error("unmatched data stored");
endmodule
`default_nettype wire

// File: test/ubr_remote.sv
// Remote serial transmitter model that drives the block's receive line.
// Assumes the bench pulses i_tick at the oversample rate, ratio 16.
`default_nettype none
module ubr_remote (
    input  wire logic i_mclk,
    input  wire logic i_tick,
    input  wire logic i_inv,
    output logic      o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEG = 16;
    logic line = 1'b1;
    // Mark level between frames, as the pull-up leaves it
    assign o_line = line ^ i_inv;
    // One bit of SEG ticks; flip puts one wrong sample mid-bit
    task automatic hold(input logic v, input logic flip);
        for (int t = 0; t < SEG; t++)
        begin
            do @(posedge i_mclk); while (!i_tick);
            line <= (flip && t == 8) ? ~v : v;
        end
    endtask
    // Start, n data bits lsb first, stop, then two idle bits
    task automatic send(input logic [9:0] d, input int n, input logic stp, input int nzb);
        hold(1'b0, nzb == 0);
        for (int b = 0; b < n; b++)
            hold(d[b], nzb == b + 1);
        hold(stp, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Bench for the break transmitter and oversampled receiver block.
// Assumes the remote model on the receive line; tick every second clock.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        rst_n;
    logic        tick = 1'b0;
    logic        rx_line;
    logic        rem_inv;
    logic        tx;
    logic        tx_oe;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] r;
    int          err_count;
    int          check_count;
    int          low_ticks;
    logic [3:0]  brk_cfg [4] = '{4'h0, 4'h1, 4'h3, 4'he};
    int          brk_len [4] = '{10, 11, 12, 16};

    ubr_core i_dut (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_sample_tick(tick), .i_rx(rx_line),
        .o_tx(tx), .o_tx_oe(tx_oe), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata)
    );
    ubr_remote i_rem (.i_mclk(mclk), .i_tick(tick), .i_inv(rem_inv), .o_line(rx_line));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) tick <= ~tick;
    // Ticks spent with the serial output low
    always @(negedge mclk) if (!tx && tick) low_ticks++;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
    // Wait until the serial output shows lvl; running out ends the run
    task automatic wait_tx(input logic lvl, input int lim);
        for (int i = 0; i < lim && tx !== lvl; i++)
            @(negedge mclk);
        if (tx !== lvl)
        begin
            err_count++;
            give_verdict();
        end
    endtask
    // Send a frame, compare receive flags, read data if stored, clear flags
    task automatic rx_frame(input logic [9:0] d, input int n, input logic stp,
                            input int nzb, input logic [15:0] st);
        i_rem.send(d, n, stp, nzb);
        reg_rd(ubr_pkg::ADDR_STAT, r);
        chk(r & 16'h001e, st);
        if (st[1])
        begin
            reg_rd(ubr_pkg::ADDR_DATA, r);
            chk(r, {6'h0, d});
        end
        reg_wr(ubr_pkg::ADDR_STAT, 16'h003c);
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        rem_inv = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        err_count = 0;
        check_count = 0;
        low_ticks = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        reg_rd(ubr_pkg::ADDR_CFG, r);
        chk(r, 16'h1e00);
        reg_rd(ubr_pkg::ADDR_STAT, r);
        chk(r & 16'h007f, 16'h0001);
        reg_wr(3'h7, 16'hffff);
        reg_rd(ubr_pkg::ADDR_CTRL, r);
        chk(r, 16'h0000);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0001);
        rx_frame(10'h0a5, 8, 1'b1, -1, 16'h0002);
        // Second frame is noisy but lost to overrun
        i_rem.send(10'h011, 8, 1'b1, -1);
        i_rem.send(10'h022, 8, 1'b1, 3);
        reg_rd(ubr_pkg::ADDR_STAT, r);
        chk(r & 16'h001e, 16'h0006);
        reg_rd(ubr_pkg::ADDR_DATA, r);
        chk(r, 16'h0011);
        reg_wr(ubr_pkg::ADDR_STAT, 16'h003c);
        rx_frame(10'h0c3, 8, 1'b1, 3, 16'h000a);
        rx_frame(10'h03c, 8, 1'b0, -1, 16'h0012);
        rx_frame(10'h069, 8, 1'b1, -1, 16'h0002);
        reg_wr(ubr_pkg::ADDR_CFG, 16'h1e10);
        rem_inv <= 1'b1;
        rx_frame(10'h05a, 8, 1'b1, -1, 16'h0002);
        reg_wr(ubr_pkg::ADDR_CFG, 16'h1e01);
        rem_inv <= 1'b0;
        reg_wr(ubr_pkg::ADDR_MATCH, 16'h4342);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0041);
        rx_frame(10'h142, 9, 1'b1, -1, 16'h0002);
        rx_frame(10'h033, 9, 1'b1, -1, 16'h0002);
        rx_frame(10'h143, 9, 1'b1, -1, 16'h0000);
        rx_frame(10'h055, 9, 1'b1, -1, 16'h0000);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h00c1);
        rx_frame(10'h143, 9, 1'b1, -1, 16'h0002);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0001);
        rx_frame(10'h155, 9, 1'b1, -1, 16'h0002);
        // Both-edge sampling at ratio 8 gives the same 16 segments per bit
        reg_wr(ubr_pkg::ADDR_CFG, 16'h0e24);
        rx_frame(10'h0e7, 8, 1'b1, -1, 16'h0002);
        reg_wr(ubr_pkg::ADDR_CFG, 16'h1e00);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0019);
        rx_frame(10'h035, 8, 1'b1, -1, 16'h0000);
        rx_frame(10'h0b5, 8, 1'b1, -1, 16'h0002);
        reg_rd(ubr_pkg::ADDR_CTRL, r);
        chk(r & 16'h0008, 16'h0000);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0009);
        rx_frame(10'h011, 8, 1'b1, 3, 16'h0000);
        reg_rd(ubr_pkg::ADDR_CTRL, r);
        chk(r & 16'h0008, 16'h0008);
        for (int i = 0; i < 400 && r[3]; i++)
            reg_rd(ubr_pkg::ADDR_CTRL, r);
        chk(r & 16'h0008, 16'h0000);
        reg_rd(ubr_pkg::ADDR_STAT, r);
        chk(r & 16'h0020, 16'h0000);
        // Awake again: a stored character then a character time of idle sets idle
        rx_frame(10'h0a5, 8, 1'b1, -1, 16'h0002);
        repeat (400) @(posedge mclk);
        reg_rd(ubr_pkg::ADDR_STAT, r);
        chk(r & 16'h0020, 16'h0020);
        // Breaks of each length, queued behind an idle character so that
        // send-break is low again before the break reaches the shifter
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0002);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(ubr_pkg::ADDR_CFG, 16'h1e00 | 16'(brk_cfg[k]));
            low_ticks = 0;
            reg_wr(ubr_pkg::ADDR_CTRL, 16'h0006);
            reg_wr(ubr_pkg::ADDR_CTRL, 16'h0002);
            wait_tx(1'b0, 4000);
            reg_wr(ubr_pkg::ADDR_CTRL, 16'h0000);
            @(negedge mclk);
            chk(16'(tx_oe), 16'h0001);
            reg_wr(ubr_pkg::ADDR_CTRL, 16'h0002);
            wait_tx(1'b1, 2000);
            chk(16'(low_ticks), 16'(brk_len[k] * 16));
        end
        // Send-break still high as a break loads queues a second break
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0006);
        wait_tx(1'b0, 4000);
        wait_tx(1'b1, 2000);
        reg_wr(ubr_pkg::ADDR_CTRL, 16'h0002);
        @(negedge mclk);
        chk(16'(tx), 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
